/* hw/siei_defines.svh */
// Purpose : constants for the switch input edge interrupt select block
// Assumes : APB slave, 32-bit data, one word per register
// Notes   : register indices are word indices; byte address is four times the index
//
// Functional notes
// RQ1 - field code zero never raises an interrupt for that input
// RQ2 - field code one raises on a rise above the group trip level
// RQ3 - field code two raises on a fall below the group trip level
// RQ4 - field code three raises on both rising and falling crossings
// RQ5 - inputs eleven to eight use bits 23-16, judged against group c
// RQ6 - inputs seven to four use bits 15-8, judged against group b
// RQ7 - inputs three to zero use bits 7-0, judged against group a
// RQ8 - every field is read/write and resets to zero, no interrupts after reset
// RQ9 - second edge select register at index 23h resets to zero
// RQ10 - trip code selects level: 0 2V, 1 2.7V, 2 3V, 3 4V
// RQ11 - edge select register for inputs zero to eleven at index 22h, reset zero
// RQ12 - sample each result per event, compare with held result, selected crossing requests
// RQ13 - a field write only affects later crossings, never raises by itself
`ifndef SIEI_DEFINES_SVH
`define SIEI_DEFINES_SVH

// ============================================================
// register indices
`define SIEI_IDX_TRIP      8'h21
`define SIEI_IDX_LOWER     8'h22
`define SIEI_IDX_UPPER     8'h23
`define SIEI_IDX_STATE     8'h26

// ============================================================
// reset values and field layout
`define SIEI_SEL_RST       24'h000000
`define SIEI_TRIP_RST      6'h00
`define SIEI_HELD_RST      12'h000
`define SIEI_SEL_W         2
`define SIEI_GROUP_SIZE    4
`define SIEI_TRIP_A_LSB    0
`define SIEI_TRIP_B_LSB    2
`define SIEI_TRIP_C_LSB    4

// ============================================================
// trip levels in millivolts
`define SIEI_TRIP_MV_0     12'h7D0
`define SIEI_TRIP_MV_1     12'hA8C
`define SIEI_TRIP_MV_2     12'hBB8
`define SIEI_TRIP_MV_3     12'hFA0

`endif

/* hw/siei_pkg.sv */
// Purpose : shared types for the switch input edge interrupt select block
// Assumes : constants come from siei_defines.svh
// Notes   : mode order follows the two-bit field code
package siei_pkg;

   // ============================================================
   // edge select modes, in field code order
   typedef enum logic [1:0] {
      SIEI_EDGE_NONE,
      SIEI_EDGE_RISE,
      SIEI_EDGE_FALL,
      SIEI_EDGE_BOTH
   } siei_edge_mode_t;

   // ============================================================
   // software configuration handed to the datapath
   typedef struct packed {
      logic [23:0] upper_sel;
      logic [23:0] lower_sel;
      logic [5:0]  trip;
   } siei_cfg_t;

endpackage : siei_pkg

/* hw/siei_edge_detect.sv */
// Purpose : per-input crossing detector with edge select
// Assumes : level_i is the comparator result, high above the trip level
// Notes   : the first sample after reset only loads the held result
`timescale 1ns/10ps
`include "siei_defines.svh"
module siei_edge_detect
   import siei_pkg::*;
#(
   parameter int N = 12
)(
   input  wire logic           sys_clk_i,
   input  wire logic           rst_i,
   input  wire logic           sample_i,
   input  wire logic [N-1:0]   level_i,
   input  wire logic [2*N-1:0] sel_i,
   output logic      [N-1:0]   hit_o,
   output logic      [N-1:0]   held_o
);

   logic [N-1:0] held_reg;
   logic [N-1:0] hit_reg;
   logic [N-1:0] hit_next;
   logic         primed_reg;

   // ============================================================
   // crossing decode, one slice per input
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_in
         siei_edge_mode_t mode;
         logic            rise;
         logic            fall;
         assign mode = siei_edge_mode_t'(sel_i[`SIEI_SEL_W*i +: `SIEI_SEL_W]);
         assign rise = level_i[i] & ~held_reg[i];   // RQ12
         assign fall = ~level_i[i] & held_reg[i];   // RQ12
         // config only gates a crossing, so a write alone cannot fire
         always_comb
         begin
            unique case (mode)
               SIEI_EDGE_NONE: hit_next[i] = 1'b0;                              // RQ1
               SIEI_EDGE_RISE: hit_next[i] = sample_i & primed_reg & rise;      // RQ2
               SIEI_EDGE_FALL: hit_next[i] = sample_i & primed_reg & fall;      // RQ3
               SIEI_EDGE_BOTH: hit_next[i] = sample_i & primed_reg & (rise | fall); // RQ4
            endcase
         end
      end
   endgenerate

   // ============================================================
   // held results move only on a sampling event
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         held_reg   <= '0;
         primed_reg <= 1'b0;
      end
      else if (sample_i)
      begin
         held_reg   <= level_i;   // RQ12
         primed_reg <= 1'b1;      // RQ13
      end
   end

   // one-cycle request per detected crossing
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         hit_reg <= '0;
      else
         hit_reg <= hit_next;     // RQ12
   end

   assign hit_o  = hit_reg;
   assign held_o = held_reg;

endmodule : siei_edge_detect

/* hw/siei_trip_decode.sv */
// Purpose : turns a two-bit trip code into its level in millivolts
// Assumes : code is stable between writes
// Notes   : output registered, one cycle behind the code
`timescale 1ns/10ps
`include "siei_defines.svh"
module siei_trip_decode
   import siei_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  code_i,
   output logic      [11:0] mv_o
);

   logic [11:0] mv_reg;

   // ============================================================
   // code to level
   function automatic logic [11:0] siei_trip_mv(input logic [1:0] code);
      unique case (code)
         2'h0: siei_trip_mv = `SIEI_TRIP_MV_0;
         2'h1: siei_trip_mv = `SIEI_TRIP_MV_1;
         2'h2: siei_trip_mv = `SIEI_TRIP_MV_2;
         2'h3: siei_trip_mv = `SIEI_TRIP_MV_3;
      endcase
   endfunction : siei_trip_mv

   // registered so the comparator reference never glitches
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         mv_reg <= `SIEI_TRIP_MV_0;
      else
         mv_reg <= siei_trip_mv(code_i);   // RQ10
   end

   assign mv_o = mv_reg;

endmodule : siei_trip_decode

/* hw/siei_top.sv */
// Purpose : edge interrupt select registers and crossing detection, APB slave
// Assumes : comparator results and sample strobe synchronous to sys_clk_i
// Notes   : no wait states on any transfer; unmapped addresses give pslverr
`timescale 1ns/10ps
`include "siei_defines.svh"
module siei_top
   import siei_pkg::*;
#(
   parameter int N_IN  = 12,
   parameter int N_GRP = 3
)(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              sample_i,
   input  wire logic [N_IN-1:0]   comp_level_i,
   output logic      [N_IN-1:0]   irq_event_o,
   output logic      [N_GRP*2-1:0] trip_code_o,
   output logic      [N_GRP*12-1:0] trip_mv_o,
   output logic      [23:0]       upper_sel_o
);

   siei_cfg_t   cfg_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        setup;
   logic        wr_done;
   logic        mapped;
   logic [31:0] rd_data;
   logic [N_IN-1:0] held;
   logic [1:0]  grp_code [N_GRP];

   // ============================================================
   // address decode; a word index hit needs an aligned address
   function automatic logic siei_hit(input logic [11:0] addr, input logic [7:0] idx);
      siei_hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
   endfunction : siei_hit

   assign setup   = psel_i & ~penable_i;
   assign wr_done = psel_i & penable_i & pready_reg & pwrite_i;
   assign mapped  = siei_hit(paddr_i, `SIEI_IDX_TRIP)  | siei_hit(paddr_i, `SIEI_IDX_LOWER) |
                    siei_hit(paddr_i, `SIEI_IDX_UPPER) | siei_hit(paddr_i, `SIEI_IDX_STATE);

   // read mux; reserved bits read as zero
   always_comb
   begin
      rd_data = 32'h00000000;
      if (siei_hit(paddr_i, `SIEI_IDX_TRIP))
         rd_data = {26'h0, cfg_reg.trip};
      else if (siei_hit(paddr_i, `SIEI_IDX_LOWER))
         rd_data = {8'h00, cfg_reg.lower_sel};   // RQ8
      else if (siei_hit(paddr_i, `SIEI_IDX_UPPER))
         rd_data = {8'h00, cfg_reg.upper_sel};
      else if (siei_hit(paddr_i, `SIEI_IDX_STATE))
         rd_data = {20'h00000, held};
   end

   // ============================================================
   // apb handshake: ready in the first access cycle only
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         pready_reg <= 1'b0;
      else
         pready_reg <= setup;
   end

   // read data and error captured in setup, held through the access cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
      else if (setup)
      begin
         prdata_reg  <= pwrite_i ? 32'h00000000 : rd_data;
         pslverr_reg <= ~mapped;
      end
      else
      begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
   end

   // ============================================================
   // configuration registers; writes land at the completing edge
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         cfg_reg.lower_sel <= `SIEI_SEL_RST;                  // RQ8
      else if (wr_done && siei_hit(paddr_i, `SIEI_IDX_LOWER))
         cfg_reg.lower_sel <= pwdata_i[23:0];                 // RQ11
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         cfg_reg.upper_sel <= `SIEI_SEL_RST;                  // RQ9
      else if (wr_done && siei_hit(paddr_i, `SIEI_IDX_UPPER))
         cfg_reg.upper_sel <= pwdata_i[23:0];                 // RQ9
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         cfg_reg.trip <= `SIEI_TRIP_RST;
      else if (wr_done && siei_hit(paddr_i, `SIEI_IDX_TRIP))
         cfg_reg.trip <= pwdata_i[5:0];                       // RQ10
   end

   // ============================================================
   // crossing detection for the lower twelve inputs
   // field i sits at bits 2i+1:2i, so 11..8 land in 23-16, 7..4 in 15-8
   siei_edge_detect #(
      .N        (N_IN)
   ) u_edge (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .sample_i  (sample_i),
      .level_i   (comp_level_i),
      .sel_i     (cfg_reg.lower_sel[2*N_IN-1:0]),             // RQ5 RQ6 RQ7
      .hit_o     (irq_event_o),
      .held_o    (held)
   );

   // ============================================================
   // group trip codes: a for inputs 0-3, b for 4-7, c for 8-11
   assign grp_code[0] = cfg_reg.trip[`SIEI_TRIP_A_LSB +: 2];  // RQ7
   assign grp_code[1] = cfg_reg.trip[`SIEI_TRIP_B_LSB +: 2];  // RQ6
   assign grp_code[2] = cfg_reg.trip[`SIEI_TRIP_C_LSB +: 2];  // RQ5

   genvar g;
   generate
      for (g = 0; g < N_GRP; g++)
      begin : g_grp
         siei_trip_decode u_dec (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .code_i    (grp_code[g]),
            .mv_o      (trip_mv_o[12*g +: 12])                // RQ10
         );
      end
   endgenerate

   // ============================================================
   // outputs straight from flops
   assign prdata_o    = prdata_reg;
   assign pready_o    = pready_reg;
   assign pslverr_o   = pslverr_reg;
   assign trip_code_o = cfg_reg.trip;
   assign upper_sel_o = cfg_reg.upper_sel;

endmodule : siei_top

/* tb/siei_sva.sv */
// Purpose : port assertions for the edge select block
// Assumes : lower select is shadowed from apb writes
// Notes   : a sample on a write edge sees the old field value
`timescale 1ns/10ps
`include "siei_defines.svh"
module siei_sva
   import siei_pkg::*;
#(
   parameter int N_IN  = 12,
   parameter int N_GRP = 3
)(
   input wire logic                sys_clk_i,
   input wire logic                rst_i,
   input wire logic                psel_i,
   input wire logic                penable_i,
   input wire logic                pwrite_i,
   input wire logic [11:0]         paddr_i,
   input wire logic [31:0]         pwdata_i,
   input wire logic [31:0]         prdata_o,
   input wire logic                pready_o,
   input wire logic                pslverr_o,
   input wire logic                sample_i,
   input wire logic [N_IN-1:0]     comp_level_i,
   input wire logic [N_IN-1:0]     irq_event_o,
   input wire logic [N_GRP*2-1:0]  trip_code_o,
   input wire logic [N_GRP*12-1:0] trip_mv_o,
   input wire logic [23:0]         upper_sel_o
);
   logic [23:0] sel_reg, sv_reg;
   logic [11:0] held_reg, rise_reg, fall_reg;
   logic        primed_reg;
   wire         acc = psel_i & penable_i & pready_o;
   function automatic logic [11:0] mk(input logic [23:0] s, input logic [1:0] c);
      for (int i = 0; i < 12; i++)
         mk[i] = (s[2*i +: 2] == c);
   endfunction : mk
   function automatic logic [11:0] lv(input logic [1:0] c);
      lv = c[1] ? (c[0] ? `SIEI_TRIP_MV_3 : `SIEI_TRIP_MV_2)
                : (c[0] ? `SIEI_TRIP_MV_1 : `SIEI_TRIP_MV_0);
   endfunction : lv
   // ============================================================
   // shadow model; the first sample only primes, so nothing may fire
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         sel_reg <= 24'h000000;
         sv_reg <= 24'h000000;
         held_reg <= 12'h000;
         primed_reg <= 1'b0;
         rise_reg <= 12'h000;
         fall_reg <= 12'h000;
      end
      else
      begin
         if (acc && pwrite_i && paddr_i == 12'h088)
            sel_reg <= pwdata_i[23:0];
         if (sample_i)
         begin
            held_reg <= comp_level_i;
            primed_reg <= 1'b1;
            sv_reg <= sel_reg;
         end
         rise_reg <= (sample_i && primed_reg) ? (~held_reg & comp_level_i) : 12'h000;
         fall_reg <= (sample_i && primed_reg) ? (held_reg & ~comp_level_i) : 12'h000;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_off_silent: assert property ((irq_event_o & mk(sv_reg, 2'h0)) == 12'h000)
      else $error("irq on a disabled input");
   a_rise_fires: assert property (((irq_event_o ^ rise_reg) & mk(sv_reg, 2'h1)) == 12'h000)
      else $error("rise select irq wrong");
   a_fall_fires: assert property (((irq_event_o ^ fall_reg) & mk(sv_reg, 2'h2)) == 12'h000)
      else $error("fall select irq wrong");
   a_both_fires: assert property
      (((irq_event_o ^ (rise_reg | fall_reg)) & mk(sv_reg, 2'h3)) == 12'h000)
      else $error("both select irq wrong");
   a_grp_a_level: assert property (trip_mv_o[11:0] == lv($past(trip_code_o[1:0])))
      else $error("group a level wrong");
   a_grp_b_level: assert property (trip_mv_o[23:12] == lv($past(trip_code_o[3:2])))
      else $error("group b level wrong");
   a_grp_c_level: assert property (trip_mv_o[35:24] == lv($past(trip_code_o[5:4])))
      else $error("group c level wrong");
   a_ready_once: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("ready timing wrong");
   a_upper_write: assert property (acc && pwrite_i && paddr_i == 12'h08C |=>
      upper_sel_o == $past(pwdata_i[23:0])) else $error("upper select not written");
   a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
      irq_event_o == 12'h000 && upper_sel_o == 24'h000000) else $error("reset value wrong");
   cover property (irq_event_o != 12'h000);
   cover property (acc && pslverr_o);
   cover property (acc && pwrite_i && paddr_i == 12'h088);
endmodule : siei_sva
bind siei_top siei_sva #(.N_IN(N_IN), .N_GRP(N_GRP)) i_siei_sva (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .sample_i(sample_i), .comp_level_i(comp_level_i),
   .irq_event_o(irq_event_o), .trip_code_o(trip_code_o), .trip_mv_o(trip_mv_o),
   .upper_sel_o(upper_sel_o));

/* tb/siei_comp_model.sv */
// Purpose : comparator side, one sample strobe per call
// Assumes : design samples on the strobe edge only
// Notes   : level is inverted between samples to catch stray reads
`timescale 1ns/10ps
module siei_comp_model
(
   input  wire logic   sys_clk_i,
   output logic        sample_o,
   output logic [11:0] level_o
);
   initial
   begin
      sample_o = 1'b0;
      level_o = 12'h000;
   end
   // ============================================================
   // one sampling event carrying v
   task automatic fire(input logic [11:0] v);
      @(posedge sys_clk_i);
      sample_o <= 1'b1;
      level_o <= v;
      @(posedge sys_clk_i);
      sample_o <= 1'b0;
      level_o <= ~v;
   endtask : fire
endmodule : siei_comp_model

/* tb/siei_tb_top.sv */
// Purpose : register and crossing tests for the edge select block
// Assumes : zero wait state apb slave
// Notes   : expected interrupt masks are worked out by hand
`timescale 1ns/10ps
`include "siei_defines.svh"
module siei_tb_top;
   logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0] paddr_i, comp_level_i, irq_event_o;
   logic [31:0] pwdata_i, prdata_o;
   logic [5:0]  trip_code_o;
   logic [35:0] trip_mv_o;
   logic [23:0] upper_sel_o;
   logic        sample_i;
   int          n_fail, num_checks, cyc;
   siei_top i_siei_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
      .comp_level_i(comp_level_i), .irq_event_o(irq_event_o), .trip_code_o(trip_code_o),
      .trip_mv_o(trip_mv_o), .upper_sel_o(upper_sel_o));
   siei_comp_model i_siei_comp_model (.sys_clk_i(sys_clk_i), .sample_o(sample_i),
      .level_o(comp_level_i));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // hang guard, well above the run length
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         conclude;
      end
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // ============================================================
   // apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      // no fixed wait assumed; only the hang guard ends a stuck transfer
      do
         @(posedge sys_clk_i);
      while (pready_o !== 1'b1);
      check({3'h0, pslverr_o, prdata_o}, {3'h0, err, (wr ? 32'h0 : exp)});
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   initial
   begin
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      apb(0, 12'h088, 32'h0, 32'h0, 0);
      apb(0, 12'h08C, 32'h0, 32'h0, 0);
      apb(0, 12'h090, 32'h0, 32'h0, 1);
      apb(1, 12'h088, 32'h0039E400, 32'h0, 0);
      apb(1, 12'h089, 32'h00FFFFFF, 32'h0, 1);
      apb(0, 12'h088, 32'h0, 32'h0039E400, 0);
      apb(1, 12'h08C, 32'hFFFFFFFF, 32'h0, 0);
      apb(0, 12'h08C, 32'h0, 32'h00FFFFFF, 0);
      apb(1, 12'h084, 32'h0000001B, 32'h0, 0);
      repeat (2) @(posedge sys_clk_i);
      #1 check(trip_mv_o, {`SIEI_TRIP_MV_1, `SIEI_TRIP_MV_2, `SIEI_TRIP_MV_3});
      check(trip_code_o, 6'h1B);
      i_siei_comp_model.fire(12'hFFF);
      #1 check(irq_event_o, 12'h000);
      i_siei_comp_model.fire(12'h000);
      #1 check(irq_event_o, 12'h6C0);
      i_siei_comp_model.fire(12'hFFF);
      #1 check(irq_event_o, 12'h5A0);
      i_siei_comp_model.fire(12'hFFF);
      #1 check(irq_event_o, 12'h000);
      apb(0, 12'h098, 32'h0, 32'h00000FFF, 0);
      // enable all while the level already differs from the held result
      apb(1, 12'h088, 32'h00FFFFFF, 32'h0, 0);
      #1 check(irq_event_o, 12'h000);
      i_siei_comp_model.fire(12'h000);
      #1 check(irq_event_o, 12'hFFF);
      apb(1, 12'h088, 32'h0, 32'h0, 0);
      i_siei_comp_model.fire(12'hFFF);
      #1 check(irq_event_o, 12'h000);
      // mid-run reset: fields clear and the first sample only primes again
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1 check({upper_sel_o, trip_code_o}, 30'h0);
      check(trip_mv_o, {3{`SIEI_TRIP_MV_0}});
      apb(0, 12'h088, 32'h0, 32'h0, 0);
      apb(1, 12'h088, 32'h00FFFFFF, 32'h0, 0);
      i_siei_comp_model.fire(12'hFFF);
      #1 check(irq_event_o, 12'h000);
      conclude;
   end
endmodule : siei_tb_top
